// ---- src/debounce_pkg.sv ----
package debounce_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned QUAL_TIME_MS   = 40;
    localparam int unsigned QUAL_CYCLES    = (CLK_HZ / 1000) * QUAL_TIME_MS;
    localparam int unsigned CHANNELS_DFLT  = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        NOTICE_IDLE    = 1'b1;

endpackage : debounce_pkg

// ---- src/switch_debouncer_bank.sv ----
`timescale 1ns/10ps

// Behaviour
// - Output holds until input stable 40 ms
// - Sample on clock, require fixed sample count
// - Input equals output: restart counter
// - Full count reached: load input to output
// - Notice flag updates with output change
// - Lockout makes outputs follow raw inputs
// - Drive bus only while enable low
// - Notice goes low on debounced change
// - Enable low clears, holds notice high
module switch_debouncer_bank
    import debounce_pkg::*;
#(
    parameter int unsigned CHANNELS    = CHANNELS_DFLT,
    parameter int unsigned QUAL_COUNT  = QUAL_CYCLES
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // Supply monitor
    input  wire logic                uvlo,
    // Switch side
    input  wire logic [CHANNELS-1:0] raw_contact_wires,
    // Bus side
    input  wire logic                enable_n,
    output logic      [CHANNELS-1:0] filtered_levels,
    output logic      [CHANNELS-1:0] filtered_levels_oe,
    output logic                     toggle_notice_n
);

    // ------------------------------------------------------------
    // Local sizes
    // ------------------------------------------------------------
    // Enough bits to hold the full qualification count
    localparam int unsigned   CW       = $clog2(QUAL_COUNT + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(QUAL_COUNT - 1);

    // ------------------------------------------------------------
    // Shared state
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] level_q;
    logic [CHANNELS-1:0] change;
    logic                notice_q;

    // ------------------------------------------------------------
    // Per-channel qualification
    // ------------------------------------------------------------
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        logic [CW-1:0] cnt_q;
        logic          match;
        logic [CW-1:0] run_q;

        // Equal input and output means nothing to qualify
        assign match     = (raw_contact_wires[i] == level_q[i]);
        assign change[i] = !uvlo && !match && (cnt_q == CNT_LAST);

        // --------------------------------------------------------
        // Qualification counter
        // --------------------------------------------------------
        // Restarts after a load, so a new level must hold a full run again
        always_ff @(posedge clk) begin
            if (srst || uvlo) begin
                cnt_q <= '0;
            end else if (match) begin
                cnt_q <= '0;
            end else if (cnt_q == CNT_LAST) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end

        // --------------------------------------------------------
        // Output flip-flop
        // --------------------------------------------------------
        // Lockout keeps the output transparent, so power-up shows no stale level
        always_ff @(posedge clk) begin
            if (srst) begin
                level_q[i] <= 1'b0;
            end else if (uvlo) begin
                level_q[i] <= raw_contact_wires[i];
            end else if (change[i]) begin
                level_q[i] <= raw_contact_wires[i];
            end
        end

        // --------------------------------------------------------
        // Checker helper: run of differing samples
        // --------------------------------------------------------
        // Kept apart from cnt_q so a broken counter cannot hide itself
        always_ff @(posedge clk) begin
            if (srst || uvlo) begin
                run_q <= '0;
            end else if (match) begin
                run_q <= '0;
            end else if (run_q == CNT_LAST) begin
                run_q <= '0;
            end else begin
                run_q <= run_q + 1'b1;
            end
        end

        // --------------------------------------------------------
        // Channel checks
        // --------------------------------------------------------
        a_hold_stable: assert property (@(posedge clk) disable iff (srst)
            !$past(srst) && !$past(uvlo) && $changed(level_q[i]) |-> $past(cnt_q) == CNT_LAST)
            else $error("Output changed before full qualification");

        a_cnt_restart: assert property (@(posedge clk) disable iff (srst)
            !uvlo && raw_contact_wires[i] == level_q[i] |=> cnt_q == '0)
            else $error("Counter not cleared on equal input");

        a_cnt_load: assert property (@(posedge clk) disable iff (srst)
            change[i] |=> level_q[i] == $past(raw_contact_wires[i]))
            else $error("Qualified level not loaded");

        a_uvlo_follow: assert property (@(posedge clk) disable iff (srst)
            uvlo |=> level_q[i] == $past(raw_contact_wires[i]) && cnt_q == '0)
            else $error("Lockout not transparent");

        a_no_early: assert property (@(posedge clk) disable iff (srst)
            change[i] |-> run_q == CNT_LAST)
            else $error("Change flagged before full run");

        a_run_loads: assert property (@(posedge clk) disable iff (srst)
            !uvlo && !match && run_q == CNT_LAST |-> change[i])
            else $error("Full run did not load output");

        a_cnt_bound: assert property (@(posedge clk) disable iff (srst)
            cnt_q <= CNT_LAST)
            else $error("Counter ran past last sample");

        a_cnt_step: assert property (@(posedge clk) disable iff (srst)
            !uvlo && !match && cnt_q != CNT_LAST |=> cnt_q == $past(cnt_q) + 1'b1)
            else $error("Counter skipped a sample");

        a_rise_full: assert property (@(posedge clk) disable iff (srst)
            !$past(srst) && !$past(uvlo) && $rose(level_q[i]) |-> $past(run_q) == CNT_LAST)
            else $error("Closing bounce passed early");

        a_fall_full: assert property (@(posedge clk) disable iff (srst)
            !$past(srst) && !$past(uvlo) && $fell(level_q[i]) |-> $past(run_q) == CNT_LAST)
            else $error("Opening bounce passed early");

        a_level_source: assert property (@(posedge clk) disable iff (srst)
            !$past(srst) && $changed(level_q[i]) |-> level_q[i] == $past(raw_contact_wires[i]))
            else $error("Output took a level not seen at input");

        a_uvlo_exit: assert property (@(posedge clk) disable iff (srst)
            !$past(srst) && $fell(uvlo) |-> level_q[i] == $past(raw_contact_wires[i]) && cnt_q == '0)
            else $error("Lockout exit not aligned to input");
    end

    // ------------------------------------------------------------
    // Change notice; enable low wins over a new change
    // ------------------------------------------------------------
    // A change that meets enable low is dropped, not held for later
    // Lockout clears it too, so power-up never reports a change
    always_ff @(posedge clk) begin
        if (srst || uvlo || !enable_n) begin
            notice_q <= NOTICE_IDLE;
        end else if (|change) begin
            notice_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus side
    // ------------------------------------------------------------
    // Pads sit outside; oe tells them when to drive
    // Tied-low enable means notice never reported
    assign toggle_notice_n    = notice_q;
    assign filtered_levels    = level_q;
    assign filtered_levels_oe = {CHANNELS{!enable_n}};

    // ------------------------------------------------------------
    // Notice and bus checks
    // ------------------------------------------------------------
    a_notice_set: assert property (@(posedge clk) disable iff (srst)
        enable_n && !uvlo && (|change) |=> !toggle_notice_n)
        else $error("Notice missed output change");

    a_notice_cause: assert property (@(posedge clk) disable iff (srst)
        $fell(toggle_notice_n) |-> $past(|change))
        else $error("Notice fell without qualified change");

    a_notice_clear: assert property (@(posedge clk) disable iff (srst)
        !enable_n |=> toggle_notice_n)
        else $error("Notice not held high under enable");

    a_bus_drive: assert property (@(posedge clk) disable iff (srst)
        filtered_levels_oe == {CHANNELS{!enable_n}})
        else $error("Bus drive not following enable");

    a_notice_stand: assert property (@(posedge clk) disable iff (srst)
        !toggle_notice_n && enable_n && !uvlo |=> !toggle_notice_n)
        else $error("Notice released without enable");

    a_enable_wins: assert property (@(posedge clk) disable iff (srst)
        !enable_n && (|change) |=> toggle_notice_n)
        else $error("Change latched under enable");

    a_enable_holds: assert property (@(posedge clk) disable iff (srst)
        !$past(enable_n) && !enable_n |-> toggle_notice_n)
        else $error("Notice low while enable stays low");

    a_notice_quiet: assert property (@(posedge clk) disable iff (srst)
        toggle_notice_n && !(|change) |=> toggle_notice_n)
        else $error("Notice fell with no change");

    a_level_quiet: assert property (@(posedge clk) disable iff (srst)
        !uvlo && !(|change) |=> $stable(filtered_levels))
        else $error("Output moved without qualification");

    a_change_gated: assert property (@(posedge clk) disable iff (srst)
        uvlo |-> !(|change))
        else $error("Qualified change during lockout");

    a_notice_lockout: assert property (@(posedge clk) disable iff (srst)
        uvlo |=> toggle_notice_n)
        else $error("Notice raised by lockout");

endmodule : switch_debouncer_bank

// ---- testbench/host_bus_model.sv ----
`timescale 1ns/10ps
module host_bus_model (
    // Bus wires seen by the host
    input  wire logic       clk,
    input  wire logic [7:0] lvl,
    input  wire logic [7:0] oe,
    output logic      [7:0] bus
);
    logic [7:0] last_q;
    // Undriven bits flip each cycle so a stale value never looks valid
    always_ff @(posedge clk) last_q <= bus;
    assign bus = (oe & lvl) | (~oe & ~last_q);
endmodule : host_bus_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(n,e,s) begin samples_checked++; if ((s)!==(e)) begin error_cnt++; $display("ERROR %s exp %h got %h",n,e,s); end end
module tb_top;
    import debounce_pkg::*;
    logic       clk = 0, srst = 1, uvlo = 0, enable_n = 1, notice_n;
    logic [7:0] raw = 8'h00, lvl, oe, bus;
    int         error_cnt = 0, samples_checked = 0;
    always #50 clk = ~clk;
    switch_debouncer_bank #(.CHANNELS(8), .QUAL_COUNT(8)) switch_debouncer_bank_inst (.clk(clk), .srst(srst),
        .uvlo(uvlo), .raw_contact_wires(raw), .enable_n(enable_n), .filtered_levels(lvl),
        .filtered_levels_oe(oe), .toggle_notice_n(notice_n));
    host_bus_model host_bus_model_inst (.clk(clk), .lvl(lvl), .oe(oe), .bus(bus));
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    task report_and_stop;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // Bounce one sample short, then a full qualification run
    task t_qualify;
        raw = 8'hff;
        wait_n(7);
        raw = 8'h00;
        wait_n(1);
        raw = 8'hff;
        wait_n(7);
        `CHK("level early", 8'h00, lvl)
        wait_n(1);
        `CHK("level", 8'hff, lvl)
        `CHK("notice", 1'b0, notice_n)
    endtask : t_qualify
    task t_enable;
        enable_n = 0;
        raw = 8'h00;
        #1 `CHK("oe", 8'hff, oe)
        `CHK("bus", 8'hff, bus)
        wait_n(9);
        `CHK("notice clear", 1'b1, notice_n)
        `CHK("level low", 8'h00, lvl)
        enable_n = 1;
        #1 `CHK("oe off", 8'h00, oe)
    endtask : t_enable
    task t_lockout;
        wait_n(1);
        raw = 8'h5a;
        uvlo = 1;
        wait_n(1);
        `CHK("transparent", 8'h5a, lvl)
        uvlo = 0;
        wait_n(9);
        `CHK("exit level", 8'h5a, lvl)
        `CHK("exit notice", 1'b1, notice_n)
    endtask : t_lockout
    initial begin
        wait_n(2);
        srst = 0;
        `CHK("reset level", 8'h00, lvl)
        `CHK("reset notice", NOTICE_IDLE, notice_n)
        t_qualify();
        t_enable();
        t_lockout();
        report_and_stop();
    end
    // Tests take under 40 cycles
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_top
